//--- design/tw_master.sv
// Two-wire bus master with a byte-wide strobed host port
// What this block does
// - Address byte is seven address bits then direction bit in the LSB.
// - Every address and data byte goes out most significant bit first.
// - Write cycles shift out held data; read cycles capture into the shifter.
// - Each data cycle ends in stop, burst continuation or repeated start.
// - Exactly one interrupt per data cycle, one per byte in bursts.
// - Turnaround runs start, address, data, restart, address, data, stop.
// - After a restart a new address byte carries the new direction.
// - All logic runs on the single primary clock.
// - Selected register loads from host bus on rising write strobe edge.
// - Data select with write strobe stores all eight bits for writing.
// - Address select with write strobe stores low seven bits as address.
// - Command write stores three bits, starts the cycle, clears interrupt.
// - Command select with read strobe returns the status register.
// - Eight-bit count times SCL low phase and restart setup.
// - Eight-bit count times SCL high phase, start hold, stop setup.
// - Eight-bit count sets bus-free interval before any start.
// - Interrupt rises on completion or abort, holds until next command write.
// - Command bits: 0 read, 1 stop, 2 repeated start.
// - Status bit 2 is lost arbitration, bit 1 is acknowledge timeout.
// - Both lines must stay high the full idle count; low restarts it.
// - Driven data mismatch during SCL high aborts with arbitration lost.
`timescale 1ns/1ps
module tw_master
    import tw_pkg::*;
(
    input  wire logic       CLK,
    input  wire logic       RST,
    input  wire logic       RD_N,
    input  wire logic       RX_DATA_SELECT,
    input  wire logic       WR_N,
    input  wire logic [7:0] HOST_WRITE_BUS,
    input  wire logic       DATA_WRITE_SELECT,
    input  wire logic       ADDR_WRITE_SELECT,
    input  wire logic       CMD_STAT_SELECT,
    input  wire logic       LOW_PHASE_WRITE_SELECT,
    input  wire logic       HIGH_PHASE_WRITE_SELECT,
    input  wire logic       IDLE_COUNT_WRITE_SELECT,
    output logic            INTERRUPT,
    output logic      [7:0] HOST_READ_BUS,
    input  wire logic       SDA_IN,
    output logic            SDA_OUT,
    output logic            SDA_OE,
    input  wire logic       SCL_IN,
    output logic            SCL_OUT,
    output logic            SCL_OE
);
    // Two-rank synchronisers for every pin; host strobes are asynchronous too
    logic [SYNC_WIDTH-1:0] sync1_q;
    logic [SYNC_WIDTH-1:0] sync2_q;
    logic                  wr_prev_q;
    wire  [SYNC_WIDTH-1:0] pins = {RD_N, RX_DATA_SELECT, WR_N, HOST_WRITE_BUS,
                                   DATA_WRITE_SELECT, ADDR_WRITE_SELECT, CMD_STAT_SELECT,
                                   LOW_PHASE_WRITE_SELECT, HIGH_PHASE_WRITE_SELECT,
                                   IDLE_COUNT_WRITE_SELECT, SDA_IN, SCL_IN};

    always_ff @(posedge CLK) begin
        if (RST) begin
            sync1_q   <= '1;
            sync2_q   <= '1;
            wr_prev_q <= 1'b1;
        end else begin
            sync1_q   <= pins;
            sync2_q   <= sync1_q;
            wr_prev_q <= sync2_q[16];
        end
    end

    wire       rd_n_s    = sync2_q[18];
    wire       rx_sel_s  = sync2_q[17];
    wire       wr_n_s    = sync2_q[16];
    wire [7:0] din_s     = sync2_q[15:8];
    wire       dsel_s    = sync2_q[7];
    wire       asel_s    = sync2_q[6];
    wire       csel_s    = sync2_q[5];
    wire       lsel_s    = sync2_q[4];
    wire       hsel_s    = sync2_q[3];
    wire       isel_s    = sync2_q[2];
    wire       sda_s     = sync2_q[1];
    wire       scl_s     = sync2_q[0];
    wire       wr_rise   = wr_n_s & ~wr_prev_q;
    wire       cmd_wr    = wr_rise & csel_s;

    // Host registers
    logic [7:0]           transmit_data_q;
    logic [6:0]           slave_address_q;
    logic [CMD_WIDTH-1:0] operation_command_q;
    logic [7:0]           scl_low_phase_count_q;
    logic [7:0]           scl_high_phase_count_q;
    logic [7:0]           bus_idle_count_q;

    always_ff @(posedge CLK) begin
        if (RST) begin
            transmit_data_q        <= DATA_RESET;
            slave_address_q        <= ADDR_RESET;
            operation_command_q    <= CMD_RESET;
            scl_low_phase_count_q  <= LOW_CNT_RESET;
            scl_high_phase_count_q <= HIGH_CNT_RESET;
            bus_idle_count_q       <= IDLE_CNT_RESET;
        end else if (wr_rise) begin
            if (dsel_s) transmit_data_q <= din_s;
            if (asel_s) slave_address_q <= din_s[ADDR_WIDTH-1:0];
            if (csel_s) operation_command_q <= din_s[CMD_WIDTH-1:0];
            if (lsel_s) scl_low_phase_count_q <= din_s;
            if (hsel_s) scl_high_phase_count_q <= din_s;
            if (isel_s) bus_idle_count_q <= din_s;
        end
    end

    wire cmd_read = operation_command_q[CMD_READ_BIT];
    wire cmd_stop = operation_command_q[CMD_STOP_BIT];
    wire cmd_rs   = operation_command_q[CMD_RS_BIT];

    // Serial engine
    tw_state_type state_q;
    logic [7:0]   cnt_q;
    logic [7:0]   byte_shifter_q;
    logic [3:0]   bit_q;
    logic         addr_phase_q;
    logic         pend_rs_q;
    logic         irq_q;
    logic         arbitration_lost_flag_q;
    logic         timeout_q;
    logic         sda_oe_q;
    logic         scl_oe_q;
    logic         data_done_q;

    wire cnt_zero  = (cnt_q == 8'h00);
    wire lines_low = ~sda_s | ~scl_s;
    wire is_ack    = (bit_q == ACK_SLOT);
    // Address bytes and write data are driven by us; read data by the slave
    wire we_send   = addr_phase_q | ~cmd_read;
    // NACK the last read byte of a run so the slave lets go of SDA
    wire ack_drive = ~cmd_stop & ~cmd_rs;
    wire drive_low = is_ack ? (~we_send & ack_drive)
                            : (we_send & ~byte_shifter_q[7]);
    wire bit_end   = (state_q == TW_HIGH) & cnt_zero & scl_s;
    wire arb_miss  = bit_end & ~sda_s & ~sda_oe_q &
                     (is_ack ? (~we_send & ~ack_drive) : we_send);
    wire ack_miss  = bit_end & is_ack & we_send & sda_s;
    wire addr_byte_done = bit_end & is_ack & ~arb_miss & ~ack_miss & addr_phase_q;
    wire data_byte_done = bit_end & is_ack & ~arb_miss & ~ack_miss & ~addr_phase_q;
    wire [7:0] status = {5'h00, arbitration_lost_flag_q, timeout_q, irq_q};

    always_ff @(posedge CLK) begin
        if (RST) begin
            state_q        <= TW_IDLE;
            cnt_q          <= 8'h00;
            byte_shifter_q <= 8'h00;
            bit_q          <= 4'h0;
            addr_phase_q   <= 1'b0;
            pend_rs_q      <= 1'b0;
            sda_oe_q       <= 1'b0;
            scl_oe_q       <= 1'b0;
        end else begin
            case (state_q)
                TW_IDLE: begin
                    sda_oe_q <= 1'b0;
                    scl_oe_q <= 1'b0;
                    if (cmd_wr) begin
                        state_q      <= TW_FREE;
                        cnt_q        <= bus_idle_count_q;
                        addr_phase_q <= 1'b1;
                    end
                end
                TW_FREE: begin
                    // Another master seen: start the idle count over
                    if (lines_low) begin
                        cnt_q <= bus_idle_count_q;
                    end else if (cnt_zero) begin
                        state_q  <= TW_START;
                        sda_oe_q <= 1'b1;
                        cnt_q    <= scl_high_phase_count_q;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                TW_START: begin
                    if (cnt_zero) begin
                        state_q        <= TW_LOW;
                        scl_oe_q       <= 1'b1;
                        cnt_q          <= scl_low_phase_count_q;
                        byte_shifter_q <= {slave_address_q, cmd_read};
                        bit_q          <= 4'h0;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                TW_LOW: begin
                    // SDA changes only while SCL is held low
                    sda_oe_q <= drive_low;
                    if (cnt_zero) begin
                        state_q  <= TW_HIGH;
                        scl_oe_q <= 1'b0;
                        cnt_q    <= scl_high_phase_count_q;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                TW_HIGH: begin
                    // A slave stretching SCL holds the high count in reload
                    if (!scl_s) begin
                        cnt_q <= scl_high_phase_count_q;
                    end else if (!cnt_zero) begin
                        cnt_q <= cnt_q - 8'h01;
                    end else if (arb_miss) begin
                        state_q  <= TW_IDLE;
                        sda_oe_q <= 1'b0;
                    end else if (ack_miss) begin
                        state_q  <= TW_STOP_LOW;
                        scl_oe_q <= 1'b1;
                        cnt_q    <= scl_low_phase_count_q;
                    end else if (!is_ack) begin
                        byte_shifter_q <= {byte_shifter_q[6:0], sda_s};
                        bit_q          <= bit_q + 4'h1;
                        state_q        <= TW_LOW;
                        scl_oe_q       <= 1'b1;
                        cnt_q          <= scl_low_phase_count_q;
                    end else if (addr_phase_q) begin
                        addr_phase_q <= 1'b0;
                        bit_q        <= 4'h0;
                        if (!cmd_read) byte_shifter_q <= transmit_data_q;
                        state_q      <= TW_LOW;
                        scl_oe_q     <= 1'b1;
                        cnt_q        <= scl_low_phase_count_q;
                    end else if (cmd_stop) begin
                        state_q  <= TW_STOP_LOW;
                        scl_oe_q <= 1'b1;
                        cnt_q    <= scl_low_phase_count_q;
                    end else begin
                        // Stretch SCL until the host writes the next command
                        state_q   <= TW_WAIT;
                        scl_oe_q  <= 1'b1;
                        pend_rs_q <= cmd_rs;
                    end
                end
                TW_WAIT: begin
                    if (cmd_wr && pend_rs_q) begin
                        state_q      <= TW_RS;
                        sda_oe_q     <= 1'b0;
                        addr_phase_q <= 1'b1;
                        cnt_q        <= scl_low_phase_count_q;
                    end else if (cmd_wr) begin
                        // Burst: data byte with no fresh address
                        bit_q          <= 4'h0;
                        byte_shifter_q <= din_s[CMD_READ_BIT] ? byte_shifter_q
                                                              : transmit_data_q;
                        state_q        <= TW_LOW;
                        cnt_q          <= scl_low_phase_count_q;
                    end
                end
                TW_RS: begin
                    // SDA released while SCL low, then SCL released; the
                    // idle check below also covers the restart setup time
                    if (cnt_zero) begin
                        state_q  <= TW_FREE;
                        scl_oe_q <= 1'b0;
                        cnt_q    <= bus_idle_count_q;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                TW_STOP_LOW: begin
                    sda_oe_q <= 1'b1;
                    if (cnt_zero) begin
                        state_q  <= TW_STOP_HIGH;
                        scl_oe_q <= 1'b0;
                        cnt_q    <= scl_high_phase_count_q;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                TW_STOP_HIGH: begin
                    if (!scl_s) begin
                        cnt_q <= scl_high_phase_count_q;
                    end else if (cnt_zero) begin
                        state_q  <= TW_IDLE;
                        sda_oe_q <= 1'b0;
                    end else begin
                        cnt_q <= cnt_q - 8'h01;
                    end
                end
                default: begin
                    state_q  <= TW_IDLE;
                    sda_oe_q <= 1'b0;
                    scl_oe_q <= 1'b0;
                end
            endcase
        end
    end

    // Interrupt and status; when a set falls in the same cycle as a command
    // write, the set wins over the clear and the flag stays high
    wire stop_end = (state_q == TW_STOP_HIGH) & scl_s & cnt_zero;
    wire irq_set  = arb_miss | stop_end | (data_byte_done & ~cmd_stop);

    always_ff @(posedge CLK) begin
        if (RST) begin
            irq_q                   <= 1'b0;
            arbitration_lost_flag_q <= 1'b0;
            timeout_q               <= 1'b0;
            data_done_q             <= 1'b0;
        end else begin
            data_done_q <= data_byte_done;
            if (irq_set) irq_q <= 1'b1;
            else if (cmd_wr) irq_q <= 1'b0;
            if (arb_miss) arbitration_lost_flag_q <= 1'b1;
            else if (cmd_wr) arbitration_lost_flag_q <= 1'b0;
            if (ack_miss) timeout_q <= 1'b1;
            else if (cmd_wr) timeout_q <= 1'b0;
        end
    end

    // Outputs, all registered
    always_ff @(posedge CLK) begin
        if (RST) begin
            INTERRUPT     <= 1'b0;
            HOST_READ_BUS <= 8'h00;
            SDA_OUT       <= 1'b0;
            SDA_OE        <= 1'b0;
            SCL_OUT       <= 1'b0;
            SCL_OE        <= 1'b0;
        end else begin
            INTERRUPT <= irq_q;
            if (!rd_n_s && csel_s) HOST_READ_BUS <= status;
            else if (!rd_n_s && rx_sel_s) HOST_READ_BUS <= byte_shifter_q;
            SDA_OUT <= 1'b0;
            SDA_OE  <= sda_oe_q;
            SCL_OUT <= 1'b0;
            SCL_OE  <= scl_oe_q;
        end
    end

    // Checks
    sequence s_cmd_write;
        cmd_wr;
    endsequence
    sequence s_irq_low;
        !irq_q ##1 !INTERRUPT;
    endsequence

    irq_clear_a: assert property (@(posedge CLK) disable iff (RST)
        s_cmd_write |=> s_irq_low)
        else $error("command write did not clear interrupt");
    irq_hold_a: assert property (@(posedge CLK) disable iff (RST)
        irq_q && !cmd_wr |=> irq_q)
        else $error("interrupt dropped without a command write");
    cmd_store_a: assert property (@(posedge CLK) disable iff (RST)
        cmd_wr |=> operation_command_q == $past(din_s[2:0]))
        else $error("command bits not stored");
    addr_load_a: assert property (@(posedge CLK) disable iff (RST)
        state_q == TW_START && cnt_zero |=>
            byte_shifter_q == {slave_address_q, cmd_read} && bit_q == 4'h0)
        else $error("address byte not loaded with direction in lsb");
    msb_first_a: assert property (@(posedge CLK) disable iff (RST)
        state_q == TW_LOW && we_send && !is_ack |=> sda_oe_q == !$past(byte_shifter_q[7]))
        else $error("serial bit is not the shifter msb");
    one_irq_a: assert property (@(posedge CLK) disable iff (RST)
        data_byte_done && !cmd_stop |=> irq_q && state_q == TW_WAIT)
        else $error("no interrupt after data byte");
    idle_restart_a: assert property (@(posedge CLK) disable iff (RST)
        state_q == TW_FREE && lines_low |=> state_q == TW_FREE && cnt_q == bus_idle_count_q)
        else $error("idle count not restarted on low line");
    arb_abort_a: assert property (@(posedge CLK) disable iff (RST)
        arb_miss |=> state_q == TW_IDLE && arbitration_lost_flag_q && irq_q ##1 INTERRUPT)
        else $error("arbitration loss not aborted");
    open_drain_a: assert property (@(posedge CLK) disable iff (RST)
        !SDA_OUT && !SCL_OUT)
        else $error("line driven high");
    status_read_a: assert property (@(posedge CLK) disable iff (RST)
        !rd_n_s && csel_s |=> HOST_READ_BUS == $past(status))
        else $error("status not returned");
    stretch_a: assert property (@(posedge CLK) disable iff (RST)
        state_q == TW_WAIT |-> scl_oe_q)
        else $error("clock not stretched while waiting");
endmodule

//--- design/tw_pkg.sv
// Constants and types shared by the two-wire bus master
package tw_pkg;
    // Command register field positions
    localparam int unsigned CMD_READ_BIT  = 0;
    localparam int unsigned CMD_STOP_BIT  = 1;
    localparam int unsigned CMD_RS_BIT    = 2;
    localparam int unsigned CMD_WIDTH     = 3;
    // Status register field positions
    localparam int unsigned STAT_IRQ_BIT  = 0;
    localparam int unsigned STAT_TMO_BIT  = 1;
    localparam int unsigned STAT_ARB_BIT  = 2;
    // Widths
    localparam int unsigned ADDR_WIDTH    = 7;
    localparam int unsigned BYTE_WIDTH    = 8;
    localparam int unsigned SYNC_WIDTH    = 19;
    // Bit index of the acknowledge slot after eight data bits
    localparam logic [3:0]  ACK_SLOT      = 4'h8;
    // Reset values of host registers
    localparam logic [7:0]  DATA_RESET    = 8'h00;
    localparam logic [6:0]  ADDR_RESET    = 7'h00;
    localparam logic [2:0]  CMD_RESET     = 3'h0;
    localparam logic [7:0]  LOW_CNT_RESET = 8'hff;
    localparam logic [7:0]  HIGH_CNT_RESET = 8'hff;
    localparam logic [7:0]  IDLE_CNT_RESET = 8'hff;

    typedef enum logic [10:0] {
        TW_IDLE      = 11'b000_0000_0001,
        TW_FREE      = 11'b000_0000_0010,
        TW_START     = 11'b000_0000_0100,
        TW_LOW       = 11'b000_0000_1000,
        TW_HIGH      = 11'b000_0001_0000,
        TW_WAIT      = 11'b000_0010_0000,
        TW_RS        = 11'b000_0100_0000,
        TW_STOP_LOW  = 11'b000_1000_0000,
        TW_STOP_HIGH = 11'b001_0000_0000
    } tw_state_type;
endpackage

//--- dv/tw_slave_model.sv
// Behavioural two-wire slave: acknowledges, records bytes, serves read data
`timescale 1ns/1ps
module tw_slave_model (
    input  wire logic       scl,
    input  wire logic       sda,
    input  wire logic       ack_en,
    input  wire logic [7:0] rd_byte,
    output logic            sda_low,
    output logic [7:0]      got_addr,
    output logic [7:0]      got_data,
    output int              addr_cnt
);
    logic [7:0] sh;
    int         bitn = 9;
    logic       addr_ph = 1'b0;
    logic       rd_mode = 1'b0;
    logic       nacked = 1'b0;
    logic       drv = 1'b0;
    assign sda_low = drv;
    // Start or repeated start rearms the address phase
    always @(negedge sda) if (scl === 1'b1) begin
        bitn = -1;
        addr_ph = 1'b1;
        nacked = 1'b0;
    end
    always @(posedge scl) begin
        if (bitn >= 0 && bitn < 8)
            sh = {sh[6:0], sda};
        if (bitn == 8 && !addr_ph && rd_mode)
            nacked = sda;
    end
    // Data changes well after SCL falls, never while it is high
    always @(negedge scl) begin
        #40;
        bitn = bitn + 1;
        if (bitn == 8) begin
            if (addr_ph) begin
                got_addr = sh;
                addr_cnt = addr_cnt + 1;
                rd_mode = sh[0];
            end else if (!rd_mode)
                got_data = sh;
            drv = ack_en && (addr_ph || !rd_mode);
        end else begin
            if (bitn == 9) begin
                bitn = 0;
                addr_ph = 1'b0;
            end
            drv = !addr_ph && rd_mode && !nacked && !rd_byte[7 - bitn];
        end
    end
endmodule

//--- dv/tw_master_tb_top.sv
// Self-checking bench for the two-wire bus master
`timescale 1ns/1ps
module tw_master_tb_top;
    import tw_pkg::*;
    logic       clk = 1'b0;
    logic       rst = 1'b1;
    logic       rd_n = 1'b1;
    logic       wr_n = 1'b1;
    logic       rx_sel = 1'b0;
    logic [5:0] sel = 6'h00;
    logic [7:0] din = 8'h00;
    logic       jam = 1'b0;
    logic       ack_en = 1'b1;
    logic [7:0] rd_byte = 8'h00;
    logic       irq, irq_q, sda_oe, sda_out, scl_oe, scl_out, sda_low;
    logic [7:0] dout, got_addr, got_data, rd_v, a, d;
    int         addr_cnt, n0, i0, s, busy;
    int         err_total = 0;
    int         cmp_count = 0;
    int         irq_cnt = 0;
    // Pull-ups on both lines; any agent pulling low wins
    wire sda = !((sda_oe && !sda_out) || sda_low || jam);
    wire scl = !(scl_oe && !scl_out);
    initial forever #10 clk = ~clk;
    always @(posedge clk) begin
        irq_q <= irq;
        if (irq === 1'b1 && irq_q === 1'b0) irq_cnt <= irq_cnt + 1;
    end
    tw_master tw_master_i (.CLK(clk), .RST(rst), .RD_N(rd_n), .RX_DATA_SELECT(rx_sel),
        .WR_N(wr_n), .HOST_WRITE_BUS(din), .DATA_WRITE_SELECT(sel[0]),
        .ADDR_WRITE_SELECT(sel[1]), .CMD_STAT_SELECT(sel[2]), .LOW_PHASE_WRITE_SELECT(sel[3]),
        .HIGH_PHASE_WRITE_SELECT(sel[4]), .IDLE_COUNT_WRITE_SELECT(sel[5]), .INTERRUPT(irq),
        .HOST_READ_BUS(dout), .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe), .SCL_IN(scl),
        .SCL_OUT(scl_out), .SCL_OE(scl_oe));
    tw_slave_model tw_slave_model_i (.scl(scl), .sda(sda), .ack_en(ack_en), .rd_byte(rd_byte),
        .sda_low(sda_low), .got_addr(got_addr), .got_data(got_data), .addr_cnt(addr_cnt));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    // Strobe levels last four cycles so the synchronised edge is never missed
    task automatic wr(input int r, input logic [7:0] v);
        @(negedge clk);
        sel = 6'h01 << r;
        din = v;
        wr_n = 1'b0;
        repeat (4) @(negedge clk);
        wr_n = 1'b1;
        repeat (4) @(negedge clk);
        sel = 6'h00;
    endtask
    task automatic rd(input logic rx, output logic [7:0] v);
        @(negedge clk);
        rx_sel = rx;
        sel = {3'h0, !rx, 2'h0};
        rd_n = 1'b0;
        repeat (6) @(negedge clk);
        v = dout;
        rd_n = 1'b1;
        rx_sel = 1'b0;
        sel = 6'h00;
    endtask
    task automatic wait_irq;
        repeat (20000) if (irq !== 1'b1) @(negedge clk);
        if (irq !== 1'b1) err_total++;
    endtask
    task automatic cmd(input logic [2:0] c, input logic [7:0] st);
        wr(2, {5'h00, c});
        chk({7'h00, irq}, 8'h00);
        wait_irq();
        rd(1'b0, rd_v);
        chk(rd_v, st);
    endtask
    // Address byte on the wire: seven address bits, direction in the lsb
    function automatic logic [7:0] addr_byte(input logic [7:0] adr, input logic dir);
        return {adr[6:0], dir};
    endfunction
    task automatic conclude;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        #1_500_000;
        err_total++;
        conclude();
    end
    initial begin
        s = $urandom(58);
        repeat (6) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        chk({7'h00, irq}, 8'h00);
        chk(dout, 8'h00);
        // Low 2 and high 1 give a serial clock period of 160 ns
        wr(3, 8'h02);
        wr(4, 8'h01);
        wr(5, 8'h04);
        for (int k = 0; k < 3; k++) begin
            a = 8'($urandom);
            d = 8'($urandom);
            wr(1, a);
            wr(0, d);
            cmd(3'h2, 8'h01);
            chk(got_addr, addr_byte(a, 1'b0));
            chk(got_data, d);
            a = 8'($urandom);
            rd_byte = 8'($urandom);
            wr(1, a);
            cmd(3'h3, 8'h01);
            chk(got_addr, addr_byte(a, 1'b1));
            rd(1'b1, rd_v);
            chk(rd_v, rd_byte);
        end
        $display("test single transfers finished");
        n0 = addr_cnt;
        i0 = irq_cnt;
        wr(1, 8'($urandom));
        for (int k = 0; k < 3; k++) begin
            d = 8'($urandom);
            wr(0, d);
            cmd((k == 2) ? 3'h2 : 3'h0, 8'h01);
            chk(got_data, d);
        end
        chk(8'(addr_cnt - n0), 8'h01);
        chk(8'(irq_cnt - i0), 8'h03);
        $display("test burst write finished");
        n0 = addr_cnt;
        a = 8'($urandom);
        d = 8'($urandom);
        rd_byte = 8'($urandom);
        wr(1, a);
        wr(0, d);
        cmd(3'h4, 8'h01);
        chk(got_data, d);
        cmd(3'h3, 8'h01);
        chk(8'(addr_cnt - n0), 8'h02);
        chk(got_addr, addr_byte(a, 1'b1));
        rd(1'b1, rd_v);
        chk(rd_v, rd_byte);
        $display("test turnaround finished");
        ack_en = 1'b0;
        cmd(3'h2, 8'h03);
        ack_en = 1'b1;
        $display("test missing acknowledge finished");
        // Another agent holds SDA low: no start may be issued meanwhile
        jam = 1'b1;
        busy = 0;
        wr(2, 8'h02);
        repeat (200) begin
            @(negedge clk);
            if (scl_oe === 1'b1 || sda_oe === 1'b1) busy++;
        end
        chk(8'(busy), 8'h00);
        jam = 1'b0;
        wait_irq();
        rd(1'b0, rd_v);
        chk(rd_v, 8'h01);
        $display("test busy bus finished");
        wr(1, 8'hff);
        wr(2, 8'h02);
        repeat (2000) if (sda_oe !== 1'b1) @(negedge clk);
        repeat (40) @(negedge clk);
        jam = 1'b1;
        wait_irq();
        rd(1'b0, rd_v);
        chk(rd_v, 8'h05);
        jam = 1'b0;
        $display("test arbitration loss finished");
        conclude();
    end
endmodule
